/* File: ecpfs_pkg.sv */
`default_nettype none
package ecpfs_pkg;
  // port modes
  localparam logic [2:0] MODE_SPP    = 3'h0;
  localparam logic [2:0] MODE_PS2    = 3'h1;
  localparam logic [2:0] MODE_PPFIFO = 3'h2;
  localparam logic [2:0] MODE_ECP    = 3'h3;
  localparam logic [2:0] MODE_TEST   = 3'h6;
  // programmed i/o offsets relative to port base
  localparam logic [10:0] OFS_PAYLOAD = 11'h400;
  localparam logic [10:0] OFS_CMD     = 11'h000;
  // fifo geometry, dma burst length and run-length limit
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [4:0]  FIFO_FULL   = 5'h10;
  localparam logic [4:0]  THR_CAP     = 5'h0f;
  localparam logic [5:0]  DMA_BURST   = 6'h20;
  localparam logic [6:0]  RLE_MAX     = 7'h7f;
  // reset values
  localparam logic [2:0]  MODE_RST    = 3'h0;
  localparam logic        MASK_RST    = 1'b1;

  // fifo entry: byte plus command marker
  typedef struct packed {
    logic       isCmd;
    logic [7:0] data;
  } ecpfs_entry_s;

  // host programmed i/o access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [10:0] addr;
    logic [7:0]  data;
  } ecpfs_pio_s;
endpackage : ecpfs_pkg
`default_nettype wire

/* File: ecpfs_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// sixteen entry fifo; full and empty derived from the count
module ecpfs_fifo (
  input  wire logic                    clock,
  input  wire logic                    rstSync_b,
  input  wire logic                    flush,
  input  wire logic                    push,
  input  wire ecpfs_pkg::ecpfs_entry_s pushData,
  input  wire logic                    pop,
  output ecpfs_pkg::ecpfs_entry_s      head,
  output logic [4:0]                   count
);
  ecpfs_pkg::ecpfs_entry_s mem [0:ecpfs_pkg::FIFO_DEPTH-1];
  logic [3:0] wrPtr;
  logic [3:0] rdPtr;
  wire        doPush = push && (count != ecpfs_pkg::FIFO_FULL);
  wire        doPop  = pop && (count != 5'h00);

  assign head = mem[rdPtr];

  // pointers and count; flush wins so a mode change discards stale bytes
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      count <= 5'h00;
    end
    else if (flush)
    begin
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      count <= 5'h00;
    end
    else
    begin
      if (doPush)
        wrPtr <= wrPtr + 4'h1;
      if (doPop)
        rdPtr <= rdPtr + 4'h1;
      count <= count + {4'h0, doPush} - {4'h0, doPop};
    end
  end

  // storage has no reset; contents only matter below count
  always_ff @(posedge clock)
  begin
    if (doPush && !flush)
      mem[wrPtr] <= pushData;
  end
endmodule : ecpfs_fifo
`default_nettype wire

/* File: ecpfs_port.sv */
`timescale 1ns/1ps
`default_nettype none
module ecpfs_port (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // configuration
  input  wire logic [2:0]           modeRequest,
  input  wire logic                 modeWrite,
  input  wire logic                 direction,
  input  wire logic                 service_irq_mask_wr,
  input  wire logic                 service_irq_mask_in,
  input  wire logic                 dma_transfer_enable,
  input  wire logic                 fault_irq_enable_low,
  input  wire logic                 ack_edge_irq_enable,
  input  wire logic [3:0]           threshold_field,
  // host programmed i/o and dma
  input  wire ecpfs_pkg::ecpfs_pio_s pio,
  input  wire logic                 dmaAck,
  input  wire logic                 dmaTc,
  input  wire logic [7:0]           dmaWriteData,
  output logic [7:0]                hostReadData,
  output logic                      dmaRequest,
  output logic                      irq,
  output logic                      service_irq_mask,
  output logic [2:0]                mode,
  output logic                      fifoFull,
  output logic                      fifoEmpty,
  // parallel link
  input  wire logic [7:0]           linkDataIn,
  input  wire logic                 periphAck,
  input  wire logic                 periphClk_b,
  input  wire logic                 fault_b,
  input  wire logic                 ack_b,
  output logic [7:0]                linkDataOut,
  output logic                      linkDataOe,
  output logic                      hostClk_b,
  output logic                      hostAck,
  output logic                      strobeOe,
  output logic                      ctrlPushPull
);
  typedef enum logic [1:0] {
    ECPFS_IDLE  = 2'b00,
    ECPFS_SETUP = 2'b01,
    ECPFS_WAIT  = 2'b10,
    ECPFS_DONE  = 2'b11
  } ecpfs_link_e;
  logic                    rstMeta_b;
  logic                    rstSync_b;
  ecpfs_link_e             linkState;
  logic [6:0]              rleCount;
  logic                    rlePending;
  logic [6:0]              rleLeft;
  logic [7:0]              rleByte;
  logic                    rleActive;
  logic [5:0]              burstCount;
  logic                    tcStop;
  logic                    faultPrev;
  logic                    ackPrev;
  logic                    errEnPrev;
  logic                    periphClkPrev;
  logic                    fifoPush;
  ecpfs_pkg::ecpfs_entry_s fifoIn;
  logic                    fifoPop;
  ecpfs_pkg::ecpfs_entry_s fifoHead;
  logic [4:0]              fifoCount;
  // threshold arithmetic shared by both service directions
  function automatic logic [4:0] svcLevel(input logic [3:0] thr);
    logic [4:0] eff;
    eff = {1'b0, thr} + 5'h01;
    if (eff > ecpfs_pkg::THR_CAP)
      eff = ecpfs_pkg::THR_CAP;
    svcLevel = ecpfs_pkg::FIFO_FULL - eff;
  endfunction : svcLevel
  // reset release through two flops
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      {rstSync_b, rstMeta_b} <= 2'b00;
    else
      {rstSync_b, rstMeta_b} <= {rstMeta_b, 1'b1};
  end
  // decode
  wire        fifoMode   = (mode == ecpfs_pkg::MODE_PPFIFO) || (mode == ecpfs_pkg::MODE_ECP)
                           || (mode == ecpfs_pkg::MODE_TEST);
  wire        ecpMode    = (mode == ecpfs_pkg::MODE_ECP);
  wire        testMode   = (mode == ecpfs_pkg::MODE_TEST);
  wire        linkMoves  = fifoMode && (mode != ecpfs_pkg::MODE_TEST);
  wire        baseMode   = (mode == ecpfs_pkg::MODE_SPP) || (mode == ecpfs_pkg::MODE_PS2);
  wire        reqBase    = (modeRequest == ecpfs_pkg::MODE_SPP)
                           || (modeRequest == ecpfs_pkg::MODE_PS2);
  // leaving ecp in reverse while a byte is still half handshaked is held off
  wire        revBusy    = ecpMode && direction && (linkState != ECPFS_IDLE);
  wire        modeOk     = modeWrite && (baseMode || reqBase) && !(reqBase && revBusy);
  wire        pioPayload = pio.addr == ecpfs_pkg::OFS_PAYLOAD;
  wire        pioCmd     = pio.addr == ecpfs_pkg::OFS_CMD;
  wire        dmaCycle   = dmaAck && dma_transfer_enable && fifoMode;
  wire [4:0]  level      = svcLevel(threshold_field);
  wire [4:0]  freeBytes  = ecpfs_pkg::FIFO_FULL - fifoCount;
  wire        svcFwd     = !dma_transfer_enable && !direction && (freeBytes >= level);
  wire        svcRev     = !dma_transfer_enable && direction && (fifoCount >= level);
  wire        svcCond    = fifoMode && !service_irq_mask && (svcFwd || svcRev);
  wire        tcEvent    = dmaTc && dmaAck && dma_transfer_enable && !service_irq_mask;
  wire        faultEvt   = !fault_irq_enable_low
                           && ((faultPrev && !fault_b) || (errEnPrev && !fault_b));
  wire        ackEvt     = ack_edge_irq_enable && !ackPrev && ack_b;
  wire        periphFall = periphClkPrev && !periphClk_b;
  wire        revRecv    = linkMoves && direction && periphFall;
  wire        revIsRle   = revRecv && !periphAck && !linkDataIn[7];
  wire        revData    = revRecv && periphAck;
  wire        fwdSend    = linkMoves && !direction && (linkState == ECPFS_IDLE)
                           && (fifoCount != 5'h00);
  // fifo feed priority: run expansion, link byte, host write, dma write
  wire        linkPush   = revData && !rlePending;
  wire        hostPush   = (!direction || testMode) && fifoMode && pio.wr
                           && (pioPayload || (pioCmd && ecpMode));
  wire        dmaPush    = !direction && dmaCycle && dmaRequest;
  wire [7:0]  pushByte   = rleActive ? rleByte : linkPush ? linkDataIn
                           : hostPush ? pio.data : dmaWriteData;
  assign fifoPush = rleActive || linkPush || hostPush || dmaPush;
  assign fifoIn   = '{isCmd: !rleActive && !linkPush && hostPush && pioCmd && ecpMode,
                      data: pushByte};
  // pops: link sends, host reads, reverse dma; test mode reads in either direction
  assign fifoPop = fwdSend
                   || ((direction || testMode) && fifoMode && pio.rd && pioPayload)
                   || (direction && dmaCycle && dmaRequest);
  ecpfs_fifo u_fifo (
    .clock    (clock),
    .rstSync_b(rstSync_b),
    .flush    (!fifoMode),
    .push     (fifoPush),
    .pushData (fifoIn),
    .pop      (fifoPop),
    .head     (fifoHead),
    .count    (fifoCount)
  );
  // mode, mask and edge history
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      mode             <= ecpfs_pkg::MODE_RST;
      service_irq_mask <= ecpfs_pkg::MASK_RST;
      faultPrev        <= 1'b1;
      ackPrev          <= 1'b1;
      errEnPrev        <= 1'b1;
      periphClkPrev    <= 1'b1;
    end
    else
    begin
      if (modeOk)
        mode <= modeRequest;
      if (tcEvent)
        service_irq_mask <= 1'b1;
      else if (service_irq_mask_wr)
        service_irq_mask <= service_irq_mask_in;
      faultPrev     <= fault_b;
      ackPrev       <= ack_b;
      errEnPrev     <= fault_irq_enable_low;
      periphClkPrev <= periphClk_b;
    end
  end
  // run-length capture and expansion
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      rlePending <= 1'b0;
      rleCount   <= 7'h00;
      rleActive  <= 1'b0;
      rleLeft    <= 7'h00;
      rleByte    <= 8'h00;
    end
    else if (!linkMoves)
    begin
      rlePending <= 1'b0;
      rleActive  <= 1'b0;
    end
    else if (rleActive)
    begin
      // fifo full stalls expansion; the peripheral is held off meanwhile
      if (fifoCount != ecpfs_pkg::FIFO_FULL)
      begin
        if (rleLeft == 7'h00)
          rleActive <= 1'b0;
        rleLeft <= rleLeft - 7'h01;
      end
    end
    else if (revIsRle)
    begin
      rlePending <= 1'b1;
      rleCount   <= linkDataIn[6:0];
    end
    else if (revData && rlePending)
    begin
      rlePending <= 1'b0;
      rleActive  <= 1'b1;
      rleLeft    <= rleCount;
      rleByte    <= linkDataIn;
    end
  end
  // forward handshake and reverse ack sequencing
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      linkState   <= ECPFS_IDLE;
      linkDataOut <= 8'h00;
      hostAck     <= 1'b1;
      hostClk_b   <= 1'b1;
    end
    else if (!linkMoves)
    begin
      linkState <= ECPFS_IDLE;
      hostClk_b <= 1'b1;
      hostAck   <= 1'b1;
    end
    else
    begin
      case (linkState)
        ECPFS_IDLE:
        begin
          if (fwdSend)
          begin
            linkDataOut <= fifoHead.data;
            hostAck     <= !fifoHead.isCmd;
            linkState   <= ECPFS_SETUP;
          end
          else if (direction && periphFall && !rleActive)
          begin
            hostAck   <= 1'b1;
            linkState <= ECPFS_DONE;
          end
        end
        ECPFS_SETUP:
        begin
          hostClk_b <= 1'b0;
          linkState <= ECPFS_WAIT;
        end
        ECPFS_WAIT:
        begin
          if (periphAck)
          begin
            hostClk_b <= 1'b1;
            linkState <= ECPFS_DONE;
          end
        end
        ECPFS_DONE:
        begin
          if (!periphAck || (direction && periphClk_b))
          begin
            hostAck   <= direction ? 1'b0 : 1'b1;
            linkState <= ECPFS_IDLE;
          end
        end
        default:
          linkState <= ECPFS_IDLE;
      endcase
    end
  end
  // dma request with burst limit and terminal-count hold
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      dmaRequest <= 1'b0;
      burstCount <= 6'h00;
      tcStop     <= 1'b0;
    end
    else
    begin
      if (tcEvent)
        tcStop <= 1'b1;
      else if (!service_irq_mask)
        tcStop <= 1'b0;
      if (dmaCycle && dmaRequest)
        burstCount <= burstCount + 6'h01;
      else if (!dmaRequest)
        burstCount <= 6'h00;
      dmaRequest <= fifoMode && dma_transfer_enable && !service_irq_mask && !tcStop
                    && !tcEvent && (burstCount < ecpfs_pkg::DMA_BURST - 6'h01)
                    && (direction ? (fifoCount > 5'h01 || (fifoCount == 5'h01 && !fifoPop))
                                  : (fifoCount < ecpfs_pkg::FIFO_FULL - 5'h01));
    end
  end
  // registered outputs
  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      irq          <= 1'b0;
      hostReadData <= 8'h00;
      fifoFull     <= 1'b0;
      fifoEmpty    <= 1'b1;
      linkDataOe   <= 1'b0;
      strobeOe     <= 1'b1;
      ctrlPushPull <= 1'b0;
    end
    else
    begin
      irq          <= svcCond || tcEvent || faultEvt || ackEvt;
      hostReadData <= fifoHead.data;
      fifoFull     <= fifoCount == ecpfs_pkg::FIFO_FULL;
      fifoEmpty    <= fifoCount == 5'h00;
      linkDataOe   <= !direction;
      strobeOe     <= 1'b1;
      ctrlPushPull <= mode != ecpfs_pkg::MODE_SPP;
    end
  end
endmodule : ecpfs_port
`default_nettype wire

/* File: ecpfs_port_props.sv */
`timescale 1ns/1ps
`default_nettype none
// pin-level watcher for the port engine
module ecpfs_port_chk (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       dmaAck,
  input wire logic       dmaTc,
  input wire logic       dmaRequest,
  input wire logic       irq,
  input wire logic       service_irq_mask,
  input wire logic [2:0] mode,
  input wire logic       fifoFull,
  input wire logic       fifoEmpty,
  input wire logic       dma_transfer_enable,
  input wire logic       fault_irq_enable_low,
  input wire logic       fault_b,
  input wire logic       ack_edge_irq_enable,
  input wire logic       ack_b,
  input wire logic       ctrlPushPull
);
  logic [5:0] burstCnt;
  logic       tcTaken;

  // accepted cycles while the request stays up; dropping it restarts the run
  assign tcTaken = dmaAck && dmaTc && dmaRequest;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      burstCnt <= 6'h00;
    else if (!dmaRequest)
      burstCnt <= 6'h00;
    else if (dmaAck)
      burstCnt <= burstCnt + 6'h01;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  mask_blocks_dma_a: assert property (
    service_irq_mask && $past(service_irq_mask) |-> !dmaRequest) else $error("request while masked");
  tc_sets_mask_a: assert property (
    tcTaken |=> service_irq_mask) else $error("mask not set by tc");
  tc_raises_irq_a: assert property (
    tcTaken && !service_irq_mask && dma_transfer_enable |-> ##[1:3] irq) else $error("no tc irq");
  full_not_empty_a: assert property (
    fifoFull |-> !fifoEmpty) else $error("full and empty together");
  spp_open_drain_a: assert property (
    mode == 3'h0 && $stable(mode) |=> !ctrlPushPull) else $error("push-pull in mode 0");
  other_push_pull_a: assert property (
    mode != 3'h0 && $stable(mode) |=> ctrlPushPull) else $error("open drain outside mode 0");
  mode_step_a: assert property (
    mode != $past(mode) |-> $past(mode) <= 3'h1 || mode <= 3'h1) else $error("illegal mode step");
  burst_cap_a: assert property (
    burstCnt <= 6'h20) else $error("dma burst too long");
  ack_edge_irq_a: assert property (
    ack_edge_irq_enable && $rose(ack_b) |-> ##[0:4] irq) else $error("no ack irq");
  fault_edge_irq_a: assert property (
    !fault_irq_enable_low && $fell(fault_b) |-> ##[0:4] irq) else $error("no fault irq");

  // main scenarios reached
  tc_seen_c: cover property (tcTaken);
  full_seen_c: cover property (fifoFull);
  long_burst_c: cover property (burstCnt == 6'h1f);
endmodule : ecpfs_port_chk

bind ecpfs_port ecpfs_port_chk ecpfs_port_chk_inst (.clock, .rst_b, .dmaAck, .dmaTc,
  .dmaRequest, .irq, .service_irq_mask, .mode, .fifoFull, .fifoEmpty, .dma_transfer_enable,
  .fault_irq_enable_low, .fault_b, .ack_edge_irq_enable, .ack_b, .ctrlPushPull);
`default_nettype wire

/* File: ecpfs_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural peripheral on the far side of the link
module ecpfs_periph_model (
  input  wire logic       clock,
  input  wire logic       hostClk_b,
  input  wire logic       hostAck,
  input  wire logic [7:0] linkDataOut,
  input  wire logic [3:0] stall,
  output logic [7:0]      linkDataIn,
  output logic            periphAck,
  output logic            periphClk_b
);
  logic [8:0] rxQ[$];

  initial
  begin
    linkDataIn = 8'h00;
    periphAck = 1'b0;
    periphClk_b = 1'b1;
  end

  // forward byte: latch marker and data, answer after a programmable stall
  always @(negedge hostClk_b)
  begin
    rxQ.push_back({hostAck, linkDataOut});
    repeat (stall) @(posedge clock);
    #1 periphAck = 1'b1;
    wait (hostClk_b);
    @(posedge clock);
    #1 periphAck = 1'b0;
  end

  // reverse byte: ack low marks a command, data line inverted once released
  task automatic send_byte(input logic isCmd, input logic [7:0] val);
    @(posedge clock);
    #1 linkDataIn = val;
    periphAck = !isCmd;
    repeat (2) @(posedge clock);
    #1 periphClk_b = 1'b0;
    repeat (2) @(posedge clock);
    #1 periphClk_b = 1'b1;
    @(posedge clock);
    #1 linkDataIn = ~val;
    periphAck = 1'b0;
  endtask : send_byte
endmodule : ecpfs_periph_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rst_b, modeWrite, direction, service_irq_mask_wr, service_irq_mask_in;
  logic dma_transfer_enable, fault_irq_enable_low, ack_edge_irq_enable, dmaAck, dmaTc;
  logic fault_b, ack_b, dmaRequest, irq, service_irq_mask, fifoFull, fifoEmpty;
  logic periphAck, periphClk_b, linkDataOe, hostClk_b, hostAck, ctrlPushPull;
  logic [2:0] modeRequest, mode;
  logic [3:0] threshold_field, stall;
  logic [7:0] dmaWriteData, hostReadData, linkDataIn, linkDataOut;
  ecpfs_pkg::ecpfs_pio_s pio;
  int bad_count, samples_checked;

  ecpfs_port ecpfs_port_inst (.clock, .rst_b, .modeRequest, .modeWrite, .direction,
    .service_irq_mask_wr, .service_irq_mask_in, .dma_transfer_enable, .fault_irq_enable_low,
    .ack_edge_irq_enable, .threshold_field, .pio, .dmaAck, .dmaTc, .dmaWriteData,
    .hostReadData, .dmaRequest, .irq, .service_irq_mask, .mode, .fifoFull, .fifoEmpty,
    .linkDataIn, .periphAck, .periphClk_b, .fault_b, .ack_b, .linkDataOut, .linkDataOe,
    .hostClk_b, .hostAck, .strobeOe(), .ctrlPushPull);
  ecpfs_periph_model ecpfs_periph_model_inst (.clock, .hostClk_b, .hostAck, .linkDataOut,
    .stall, .linkDataIn, .periphAck, .periphClk_b);

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // inputs move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic set_mode(input logic [2:0] m);
    modeRequest = m;
    modeWrite = 1'b1;
    cyc(1);
    modeWrite = 1'b0;
    cyc(1);
  endtask : set_mode

  task automatic set_mask(input logic v);
    service_irq_mask_in = v;
    service_irq_mask_wr = 1'b1;
    cyc(1);
    service_irq_mask_wr = 1'b0;
    cyc(1);
  endtask : set_mask

  task automatic pio_wr(input logic [10:0] a, input logic [7:0] d);
    pio = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    cyc(1);
    pio.wr = 1'b0;
    cyc(1);
  endtask : pio_wr

  task automatic pio_rd(input logic [7:0] exp);
    pio = '{wr: 1'b0, rd: 1'b1, addr: ecpfs_pkg::OFS_PAYLOAD, data: 8'h00};
    cyc(1);
    pio.rd = 1'b0;
    check({1'b0, hostReadData}, {1'b0, exp});
    cyc(1);
  endtask : pio_rd

  // bounded waits; running out ends the run
  task automatic wait_irq;
    for (int i = 0; i < 8 && irq !== 1'b1; i++) cyc(1);
    check({8'h00, irq}, 9'h001);
    if (irq !== 1'b1) finish_test();
  endtask : wait_irq

  task automatic dma_rd(input logic tc, input logic [7:0] exp);
    for (int i = 0; i < 300 && dmaRequest !== 1'b1; i++) cyc(1);
    check({8'h00, dmaRequest}, 9'h001);
    if (dmaRequest !== 1'b1) finish_test();
    dmaAck = 1'b1;
    dmaTc = tc;
    cyc(1);
    dmaAck = 1'b0;
    dmaTc = 1'b0;
    check({1'b0, hostReadData}, {1'b0, exp});
    check({8'h00, irq}, {8'h00, tc});
    cyc(1);
  endtask : dma_rd

  task automatic dma_wr(input logic [7:0] d);
    for (int i = 0; i < 300 && dmaRequest !== 1'b1; i++) cyc(1);
    check({8'h00, dmaRequest}, 9'h001);
    if (dmaRequest !== 1'b1) finish_test();
    dmaAck = 1'b1;
    dmaWriteData = d;
    cyc(1);
    dmaAck = 1'b0;
    cyc(1);
  endtask : dma_wr

  initial
  begin
    #400000 bad_count++;
    finish_test();
  end

  initial
  begin
    {modeWrite, direction, service_irq_mask_wr, service_irq_mask_in, dmaAck, dmaTc} = 6'h00;
    {dma_transfer_enable, ack_edge_irq_enable, rst_b} = 3'h0;
    {fault_irq_enable_low, fault_b, ack_b} = 3'h7;
    {modeRequest, threshold_field, stall, dmaWriteData} = 19'h00000;
    pio = '0;
    cyc(20);
    rst_b = 1'b1;
    cyc(3);
    check({8'h00, service_irq_mask}, 9'h001);
    check({8'h00, fifoEmpty}, 9'h001);
    set_mode(ecpfs_pkg::MODE_ECP);
    set_mode(ecpfs_pkg::MODE_PPFIFO);
    check({6'h00, mode}, 9'h003);
    check({8'h00, ctrlPushPull}, 9'h001);
    set_mode(ecpfs_pkg::MODE_SPP);
    check({8'h00, ctrlPushPull}, 9'h000);
    set_mode(ecpfs_pkg::MODE_TEST);
    // fill the test fifo past full, free space level 12
    threshold_field = 4'h3;
    for (int i = 0; i < 17; i++) pio_wr(ecpfs_pkg::OFS_PAYLOAD, 8'h30 + 8'(i));
    check({8'h00, fifoFull}, 9'h001);
    set_mask(1'b0);
    for (int i = 0; i < 11; i++) pio_rd(8'h30 + 8'(i));
    check({8'h00, irq}, 9'h000);
    pio_rd(8'h3b);
    check({8'h00, irq}, 9'h001);
    set_mask(1'b1);
    check({8'h00, irq}, 9'h000);
    set_mask(1'b0);
    check({8'h00, irq}, 9'h001);
    for (int i = 12; i < 16; i++) pio_rd(8'h30 + 8'(i));
    check({8'h00, fifoEmpty}, 9'h001);
    // reverse level with capped threshold is one byte
    set_mask(1'b1);
    set_mode(ecpfs_pkg::MODE_SPP);
    direction = 1'b1;
    threshold_field = 4'hf;
    set_mode(ecpfs_pkg::MODE_TEST);
    set_mask(1'b0);
    check({8'h00, irq}, 9'h000);
    pio_wr(ecpfs_pkg::OFS_PAYLOAD, 8'h77);
    check({8'h00, irq}, 9'h001);
    pio_rd(8'h77);
    set_mask(1'b1);
    // forward ecp: command, data, command with a slow peripheral
    set_mode(ecpfs_pkg::MODE_SPP);
    direction = 1'b0;
    set_mode(ecpfs_pkg::MODE_ECP);
    check({8'h00, linkDataOe}, 9'h001);
    stall = 4'h3;
    pio_wr(ecpfs_pkg::OFS_CMD, 8'h85);
    pio_wr(ecpfs_pkg::OFS_PAYLOAD, 8'h5a);
    pio_wr(ecpfs_pkg::OFS_CMD, 8'h10);
    for (int i = 0; i < 300 && ecpfs_periph_model_inst.rxQ.size() < 3; i++) cyc(1);
    check(9'(ecpfs_periph_model_inst.rxQ.size()), 9'h003);
    check(ecpfs_periph_model_inst.rxQ[0], 9'h085);
    check(ecpfs_periph_model_inst.rxQ[1], 9'h15a);
    check(ecpfs_periph_model_inst.rxQ[2], 9'h010);
    // reverse dma with run-length expansion, then terminal count
    cyc(20);
    set_mode(ecpfs_pkg::MODE_SPP);
    direction = 1'b1;
    threshold_field = 4'h0;
    set_mode(ecpfs_pkg::MODE_ECP);
    dma_transfer_enable = 1'b1;
    check({8'h00, linkDataOe}, 9'h000);
    set_mask(1'b0);
    ecpfs_periph_model_inst.send_byte(1'b1, 8'h7f);
    ecpfs_periph_model_inst.send_byte(1'b0, 8'hc3);
    for (int i = 0; i < 128; i++) dma_rd(1'b0, 8'hc3);
    ecpfs_periph_model_inst.send_byte(1'b1, 8'h00);
    ecpfs_periph_model_inst.send_byte(1'b0, 8'h5e);
    ecpfs_periph_model_inst.send_byte(1'b0, 8'h21);
    dma_rd(1'b0, 8'h5e);
    dma_rd(1'b1, 8'h21);
    check({8'h00, service_irq_mask}, 9'h001);
    ecpfs_periph_model_inst.send_byte(1'b0, 8'h44);
    cyc(10);
    check({8'h00, dmaRequest}, 9'h000);
    set_mask(1'b0);
    dma_rd(1'b0, 8'h44);
    set_mask(1'b1);
    // forward dma into the test fifo, read back by the host
    set_mode(ecpfs_pkg::MODE_SPP);
    direction = 1'b0;
    set_mode(ecpfs_pkg::MODE_TEST);
    set_mask(1'b0);
    dma_wr(8'h6c);
    dma_wr(8'h93);
    set_mask(1'b1);
    dma_transfer_enable = 1'b0;
    pio_rd(8'h6c);
    pio_rd(8'h93);
    // fault edge, enable falling while fault low, ack rising edge
    fault_irq_enable_low = 1'b0;
    cyc(4);
    fault_b = 1'b0;
    wait_irq();
    fault_irq_enable_low = 1'b1;
    cyc(8);
    fault_irq_enable_low = 1'b0;
    wait_irq();
    ack_edge_irq_enable = 1'b1;
    ack_b = 1'b0;
    cyc(8);
    ack_b = 1'b1;
    wait_irq();
    cyc(5);
    finish_test();
  end
endmodule : tb
`default_nettype wire
